// ===== verilog/hdc_pkg.sv
// Package of constants and types for the hall output conditioning chain
package hdc_pkg;
  // Command codes of the programming port
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_LOCK = 2'h2;
  // Setting addresses
  localparam logic [3:0] ADR_MODE = 4'h0;
  localparam logic [3:0] ADR_SENS = 4'h1;
  localparam logic [3:0] ADR_QUIES = 4'h2;
  localparam logic [3:0] ADR_CLLOW = 4'h3;
  localparam logic [3:0] ADR_CLHIGH = 4'h4;
  localparam logic [3:0] ADR_LINTC = 4'h5;
  localparam logic [3:0] ADR_QUADTC = 4'h6;
  localparam logic [3:0] ADR_READOUT = 4'h7;
  localparam logic [3:0] ADR_TRIM0 = 4'h8;
  localparam logic [3:0] ADR_TRIM1 = 4'h9;
  localparam logic [3:0] ADR_LOCK = 4'hA;
  // Mode field positions
  localparam int RANGE_LSB = 0;
  localparam int FILTER_LSB = 3;
  // Reset values of the settings
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [15:0] SENS_RST = 16'h0800;
  localparam logic [10:0] QUIES_RST = 11'h200;
  localparam logic [9:0] CLLOW_RST = 10'h000;
  localparam logic [10:0] CLHIGH_RST = 11'h7FF;
  localparam logic [7:0] LINTC_RST = 8'h00;
  localparam logic [7:0] QUADTC_RST = 8'h00;
  // Factory trim, values arbitrary
  localparam logic [15:0] TRIM0_VAL = 16'h1234;
  localparam logic [15:0] TRIM1_VAL = 16'h5678;
  // Supply window in millivolts
  localparam int VDD_MIN_MV = 4500;
  localparam int VDD_MAX_MV = 5500;
  // Full output span in DAC codes, 2048 readout counts per span
  localparam int SPAN_SHIFT = 11;
  localparam logic [11:0] DAC_MAX = 12'h7FF;
  // Programming request
  typedef struct packed {
    logic [1:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } hdc_req_s;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_PROG = 3'b010,
    ST_LOCKED = 3'b100
  } hdc_state_e;
endpackage

// ===== verilog/hdc_conditioning.sv
// Digital conditioning core of a programmable linear field sensor
`timescale 1ns/1ps
module hdc_conditioning
  import hdc_pkg::*;
#(
  parameter int SAMPLE_W = 14
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [SAMPLE_W-1:0] sample,
  input wire logic sampleValid,
  input wire logic [12:0] supplyMv,
  input wire logic [7:0] temperature,
  input wire logic selectPin,
  input wire logic cmdValid,
  input wire hdc_req_s cmdReq,
  input wire logic cmdDone,
  output logic [11:0] dacCode,
  output logic analogEnable,
  output logic [15:0] replyData,
  output logic replyValid,
  output logic [2:0] rangeSelect,
  output logic [7:0] trimOsc
);
  // Reject every width other than the 14 bits of the readout register
  if (SAMPLE_W != 14) begin : g_bad_width
    $error("hdc_conditioning: SAMPLE_W must be 14");
  end

  // Whole module state in one record
  typedef struct packed {
    hdc_state_e state;
    logic selSync1;
    logic selSync2;
    logic [5:0] mode;
    logic [15:0] sens;
    logic [10:0] quies;
    logic [9:0] clLow;
    logic [10:0] clHigh;
    logic [7:0] linTc;
    logic [7:0] quadTc;
    logic [17:0] filt;
    logic [13:0] readout;
    logic [11:0] dac;
    logic analogOn;
    logic [15:0] reply;
    logic replyV;
  } hdc_core_s;

  hdc_core_s cur;
  hdc_core_s nxt;

  // saturate a readout into the span of the filter corner
  // Converter gain differs per corner, so the span does too
  function automatic logic [13:0] sat14(input logic signed [19:0] v,
    input logic [2:0] f);
    logic signed [19:0] hi;
    logic signed [19:0] lo;
    case (f)
      3'h0: begin
        hi = 20'sh00F7F;
        lo = -20'sh00F80;
      end
      3'h1: begin
        hi = 20'sh007C1;
        lo = -20'sh007C1;
      end
      3'h2: begin
        hi = 20'sh014AA;
        lo = -20'sh014AC;
      end
      3'h3: begin
        hi = 20'sh00A55;
        lo = -20'sh00A56;
      end
      // Fastest corner, also taken by unused codes
      default: begin
        hi = 20'sh005E7;
        lo = -20'sh005E8;
      end
    endcase
    if (v > hi) begin
      sat14 = hi[13:0];
    end else if (v < lo) begin
      sat14 = lo[13:0];
    end else begin
      sat14 = v[13:0];
    end
  endfunction

  // Filter shift per corner; slower corners average longer
  function automatic logic [2:0] filtShift(input logic [2:0] f);
    case (f)
      3'h0: filtShift = 3'h6;
      3'h1: filtShift = 3'h5;
      3'h2: filtShift = 3'h4;
      3'h3: filtShift = 3'h3;
      3'h4: filtShift = 3'h2;
      default: filtShift = 3'h2;
    endcase
  endfunction

  // Comb signals of the data path
  logic signed [19:0] filtIn;
  logic signed [19:0] filtDelta;
  logic signed [19:0] filtNew;
  logic signed [15:0] effSens;
  logic signed [31:0] tcTerm;
  logic signed [31:0] prod;
  logic signed [31:0] sum;
  logic [11:0] satSum;
  logic [11:0] clamped;
  logic supplyOk;
  logic cmdForMe;
  logic [15:0] rdData;
  logic signed [8:0] dT;

  always_comb begin
    // north pole positive: sample polarity passed as signed
    filtIn = 20'(signed'(sample)) <<< 4;
    // first-order low-pass on every valid sample
    filtDelta = (filtIn - 20'(signed'(cur.filt))) >>> filtShift(
      cur.mode[FILTER_LSB +: 3]);
    filtNew = 20'(signed'(cur.filt)) + filtDelta;
    // sensitivity scaled by linear and quadratic terms
    dT = signed'({1'b0, temperature}) - 9'sd128;
    tcTerm = (32'(signed'(cur.linTc)) * 32'(dT)
      + ((32'(signed'(cur.quadTc)) * 32'(dT) * 32'(dT)) >>> 7)) >>> 6;
    effSens = 16'(32'(signed'(cur.sens))
      + ((32'(signed'(cur.sens)) * tcTerm) >>> 11));
    // unity sensitivity moves 2048 readout counts per span
    prod = (32'(signed'(cur.readout)) * 32'(effSens)) >>> SPAN_SHIFT;
    // quiescent steps are two DAC codes: full span
    sum = prod + (32'(signed'(cur.quies)) <<< 1);
    if (sum < 0) begin
      satSum = 12'h000;
    end else if (sum > 32'(DAC_MAX)) begin
      satSum = DAC_MAX;
    end else begin
      satSum = sum[11:0];
    end
    if (satSum < {2'h0, cur.clLow}) begin
      clamped = {2'h0, cur.clLow};
    end else if (satSum > {1'b0, cur.clHigh}) begin
      clamped = {1'b0, cur.clHigh};
    end else begin
      clamped = satSum;
    end
    supplyOk = (supplyMv >= 13'(VDD_MIN_MV))
      && (supplyMv <= 13'(VDD_MAX_MV));
    // only act when selected through our output pin
    cmdForMe = cmdValid && cur.selSync2;
    // Read multiplexer; trim registers are constants
    case (cmdReq.addr)
      ADR_MODE: rdData = {10'h000, cur.mode};
      ADR_SENS: rdData = cur.sens;
      ADR_QUIES: rdData = {5'h00, cur.quies};
      ADR_CLLOW: rdData = {6'h00, cur.clLow};
      ADR_CLHIGH: rdData = {5'h00, cur.clHigh};
      ADR_LINTC: rdData = {8'h00, cur.linTc};
      ADR_QUADTC: rdData = {8'h00, cur.quadTc};
      // readout as signed 14 bits, sign extended
      ADR_READOUT: rdData = {{2{cur.readout[13]}}, cur.readout};
      ADR_TRIM0: rdData = TRIM0_VAL;
      ADR_TRIM1: rdData = TRIM1_VAL;
      ADR_LOCK: rdData = {15'h0000, cur.state == ST_LOCKED};
      default: rdData = 16'h0000;
    endcase
  end

  // Next-state logic
  always_comb begin
    nxt = cur;
    nxt.replyV = 1'b0;
    // Select pin comes from outside: two flops first
    nxt.selSync1 = selectPin;
    nxt.selSync2 = cur.selSync1;
    if (sampleValid) begin
      nxt.filt = filtNew[17:0];
      // readout span follows the filter corner
      nxt.readout = sat14(filtNew >>> 4, cur.mode[FILTER_LSB +: 3]);
    end
    nxt.dac = clamped;
    case (cur.state)
      ST_RUN: begin
        // start an exchange on a command for us
        if (cmdForMe) begin
          nxt.state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (cmdDone) begin
          nxt.state = ST_RUN;
          nxt.replyV = 1'b1;
          nxt.reply = rdData;
          if (cmdReq.cmd == CMD_WRITE) begin
            case (cmdReq.addr)
              ADR_MODE: nxt.mode = cmdReq.data[5:0];
              ADR_SENS: nxt.sens = cmdReq.data;
              // signed quiescent, minus to plus span
              ADR_QUIES: nxt.quies = cmdReq.data[10:0];
              // low clamp limited to half span
              ADR_CLLOW: nxt.clLow = cmdReq.data[9:0];
              ADR_CLHIGH: nxt.clHigh = cmdReq.data[10:0];
              ADR_LINTC: nxt.linTc = cmdReq.data[7:0];
              ADR_QUADTC: nxt.quadTc = cmdReq.data[7:0];
              default: nxt.reply = rdData;
            endcase
          end else if (cmdReq.cmd == CMD_LOCK) begin
            nxt.state = ST_LOCKED;
          end
        end
      end
      ST_LOCKED: nxt.state = ST_LOCKED;
      default: nxt.state = ST_RUN;
    endcase
    // analog output only outside exchanges in band
    nxt.analogOn = supplyOk && (nxt.state != ST_PROG);
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '{state: ST_RUN, selSync1: 1'b0, selSync2: 1'b0,
        mode: MODE_RST, sens: SENS_RST, quies: QUIES_RST,
        clLow: CLLOW_RST, clHigh: CLHIGH_RST, linTc: LINTC_RST,
        quadTc: QUADTC_RST, filt: 18'h00000, readout: 14'h0000,
        dac: 12'h000, analogOn: 1'b0, reply: 16'h0000, replyV: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  assign dacCode = cur.dac;
  assign analogEnable = cur.analogOn;
  assign replyData = cur.reply;
  assign replyValid = cur.replyV;
  assign rangeSelect = cur.mode[RANGE_LSB +: 3];
  assign trimOsc = TRIM0_VAL[7:0];

  // Steps of one exchange: taken in run, then finished
  sequence s_take;
    cur.state == ST_RUN && cmdValid && cur.selSync2;
  endsequence
  sequence s_finish;
    cur.state == ST_PROG && cmdDone;
  endsequence

  a_lock_sticky: assert property (
    @(posedge clk) disable iff (!reset_n)
    cur.state == ST_LOCKED |=> cur.state == ST_LOCKED)
    else $error("lock was cleared");
  a_locked_silent: assert property (
    @(posedge clk) disable iff (!reset_n)
    $past(cur.state) == ST_LOCKED |-> !replyValid)
    else $error("locked device replied");
  a_prog_quiet: assert property (
    @(posedge clk) disable iff (!reset_n)
    cur.state == ST_PROG |-> !analogEnable)
    else $error("analog on during programming");
  a_unselected_idle: assert property (
    @(posedge clk) disable iff (!reset_n)
    cur.state == ST_RUN && cmdValid && !cur.selSync2
    |=> cur.state == ST_RUN)
    else $error("unselected device acted");
  a_supply_band: assert property (
    @(posedge clk) disable iff (!reset_n)
    supplyMv > 13'(VDD_MAX_MV) || supplyMv < 13'(VDD_MIN_MV)
    |=> !analogEnable)
    else $error("analog on outside supply band");
  a_clamp_bounds: assert property (
    @(posedge clk) disable iff (!reset_n)
    $stable(cur.clLow) && $stable(cur.clHigh) && cur.clLow <= cur.clHigh
    |=> dacCode >= {2'h0, $past(cur.clLow)}
    && dacCode <= {1'b0, $past(cur.clHigh)})
    else $error("output outside clamps");
  a_trim_fixed: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_finish ##0 (cmdReq.addr == ADR_TRIM0)
    |=> replyValid && replyData == TRIM0_VAL)
    else $error("trim not read-only");
  a_atomic_write: assert property (
    @(posedge clk) disable iff (!reset_n)
    cur.state == ST_PROG && !cmdDone |=> $stable(cur.sens)
    && $stable(cur.mode))
    else $error("setting changed mid exchange");
  a_take_exchange: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_take |=> cur.state == ST_PROG)
    else $error("selected command not taken");
  a_done_reply: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_finish |=> replyValid && cur.state != ST_PROG)
    else $error("no reply after exchange");
  a_reply_pulse: assert property (
    @(posedge clk) disable iff (!reset_n)
    replyValid |=> !replyValid)
    else $error("reply strobe held too long");
  a_readout_span: assert property (
    @(posedge clk) disable iff (!reset_n)
    sampleValid && cur.mode[FILTER_LSB +: 3] == 3'h4
    |=> $signed(cur.readout) <= 14'sh05E7
    && $signed(cur.readout) >= -14'sh05E8)
    else $error("readout outside filter span");
endmodule

// ===== verif/hdc_prog_model.sv
// Behavioural programming host that drives decoded commands
`timescale 1ns/1ps
module hdc_prog_model
  import hdc_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic slow,
  input wire hdc_req_s reqIn,
  input wire logic replyValid,
  input wire logic [15:0] replyData,
  input wire logic analogEnable,
  output logic cmdValid,
  output hdc_req_s cmdReq,
  output logic cmdDone,
  output logic busy,
  output logic gotReply,
  output logic [15:0] gotData,
  output logic sawOn
);
  // One exchange per go, prompt or slow
  initial begin
    cmdValid = 1'b0;
    cmdDone = 1'b0;
    busy = 1'b0;
    cmdReq = '0;
    gotReply = 1'b0;
    gotData = 16'h0000;
    sawOn = 1'b0;
    forever begin
      @(negedge clk);
      if (go) begin
        busy = 1'b1;
        cmdValid = 1'b1;
        cmdReq = reqIn;
        sawOn = 1'b0;
        repeat (slow ? 4 : 1) begin
          @(negedge clk);
          sawOn = sawOn | analogEnable;
        end
        cmdDone = 1'b1;
        @(negedge clk);
        gotReply = replyValid;
        gotData = replyData;
        cmdDone = 1'b0;
        cmdValid = 1'b0;
        // Released word inverted so stale data never looks valid
        cmdReq = ~cmdReq;
        busy = 1'b0;
      end
    end
  end
endmodule

// ===== verif/testbench.sv
// Self-checking bench of the conditioning core
`timescale 1ns/1ps
module testbench
  import hdc_pkg::*;
;
  typedef struct packed {
    hdc_req_s req;
    logic [15:0] exp;
  } hdc_row_s;
  // Reads return the value held before the command
  localparam hdc_row_s ROWS [15] = '{
    '{'{CMD_READ, ADR_MODE, 16'h0}, {10'h0, MODE_RST}},
    '{'{CMD_READ, ADR_SENS, 16'h0}, SENS_RST},
    '{'{CMD_READ, ADR_QUIES, 16'h0}, {5'h0, QUIES_RST}},
    '{'{CMD_READ, ADR_CLLOW, 16'h0}, {6'h0, CLLOW_RST}},
    '{'{CMD_READ, ADR_CLHIGH, 16'h0}, {5'h0, CLHIGH_RST}},
    '{'{CMD_READ, ADR_LINTC, 16'h0}, {8'h0, LINTC_RST}},
    '{'{CMD_READ, ADR_QUADTC, 16'h0}, {8'h0, QUADTC_RST}},
    '{'{CMD_WRITE, ADR_MODE, 16'h0024}, {10'h0, MODE_RST}},
    '{'{CMD_READ, ADR_MODE, 16'h0}, 16'h0024},
    '{'{CMD_WRITE, ADR_TRIM0, 16'hFFFF}, TRIM0_VAL},
    '{'{CMD_READ, ADR_TRIM0, 16'h0}, TRIM0_VAL},
    '{'{CMD_WRITE, ADR_SENS, 16'h0000}, SENS_RST},
    '{'{CMD_READ, ADR_SENS, 16'h0}, 16'h0000},
    '{'{CMD_WRITE, ADR_LINTC, 16'h0012}, {8'h0, LINTC_RST}},
    '{'{CMD_READ, ADR_LINTC, 16'h0}, 16'h0012}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [13:0] sample = 14'h0000;
  logic sampleValid = 1'b0;
  logic [12:0] supplyMv = 13'h1388;
  logic [7:0] temperature = 8'h80;
  logic selectPin = 1'b1;
  logic go = 1'b0;
  logic slowSel = 1'b0;
  hdc_req_s reqIn = '0;
  logic cmdValid, cmdDone, busy, gotReply, sawOn;
  hdc_req_s cmdReq;
  logic [11:0] dacCode;
  logic analogEnable, replyValid;
  logic [15:0] replyData, gotData;
  logic [2:0] rangeSelect;
  logic [7:0] trimOsc;
  int n_mismatch = 0;
  int num_checks = 0;
  logic [12:0] mv [4] = '{13'h1193, 13'h1194, 13'h157C, 13'h157D};
  hdc_conditioning dut (.clk(clk), .reset_n(reset_n), .sample(sample),
    .sampleValid(sampleValid), .supplyMv(supplyMv),
    .temperature(temperature), .selectPin(selectPin),
    .cmdValid(cmdValid), .cmdReq(cmdReq), .cmdDone(cmdDone),
    .dacCode(dacCode), .analogEnable(analogEnable),
    .replyData(replyData), .replyValid(replyValid),
    .rangeSelect(rangeSelect), .trimOsc(trimOsc));
  hdc_prog_model host (.clk(clk), .go(go), .slow(slowSel), .reqIn(reqIn),
    .replyValid(replyValid), .replyData(replyData),
    .analogEnable(analogEnable), .cmdValid(cmdValid), .cmdReq(cmdReq),
    .cmdDone(cmdDone), .busy(busy), .gotReply(gotReply),
    .gotData(gotData), .sawOn(sawOn));
  // 50 ns clock and a sample strobe every other cycle
  initial forever #25 clk = ~clk;
  always @(negedge clk) sampleValid <= ~sampleValid;
  // Single compare for every result kind
  task automatic chk(input string nm, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One exchange through the host, bounded wait
  task automatic cmd(input hdc_req_s r, input logic s);
    int k;
    @(negedge clk);
    reqIn <= r;
    slowSel <= s;
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (!busy) break;
    end
    if (k == 20) n_mismatch++;
    // Hand back on a falling edge so callers drive off the sampling edge
    @(negedge clk);
  endtask
  task automatic dac(input logic [15:0] q, lo, hi, e);
    cmd('{CMD_WRITE, ADR_QUIES, q}, 1'b0);
    cmd('{CMD_WRITE, ADR_CLLOW, lo}, 1'b0);
    cmd('{CMD_WRITE, ADR_CLHIGH, hi}, 1'b1);
    repeat (4) @(negedge clk);
    chk("dacCode", e, {4'h0, dacCode});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (20) @(negedge clk);
    chk("replyValid", 16'h0, {15'h0, replyValid});
    chk("rangeSelect", 16'h0, {13'h0, rangeSelect});
    reset_n <= 1'b1;
    repeat (3) @(negedge clk);
    $display("test reset done");
    foreach (ROWS[i]) begin
      cmd(ROWS[i].req, i[0]);
      chk("reply", ROWS[i].exp, gotData);
      chk("replyValid", 16'h1, {15'h0, gotReply});
      chk("analogOff", 16'h0, {15'h0, sawOn});
    end
    $display("test table done");
    chk("rangeSelect", 16'h4, {13'h0, rangeSelect});
    chk("trimOsc", 16'h34, {8'h0, trimOsc});
    dac(16'h0300, 16'h0000, 16'h07FF, 16'h0600);
    dac(16'h0300, 16'h0000, 16'h0200, 16'h0200);
    dac(16'h07C0, 16'h0010, 16'h07FF, 16'h0010);
    $display("test datapath done");
    foreach (mv[i]) begin
      supplyMv <= mv[i];
      repeat (3) @(negedge clk);
      chk("analogEnable", {15'h0, i[0] ^ i[1]}, {15'h0, analogEnable});
    end
    supplyMv <= 13'h1388;
    sample <= 14'h0400;
    repeat (40) @(negedge clk);
    cmd('{CMD_READ, ADR_READOUT, 16'h0}, 1'b0);
    chk("signNorth", 16'h0, {15'h0, gotData[13]});
    sample <= 14'h3C00;
    repeat (40) @(negedge clk);
    cmd('{CMD_READ, ADR_READOUT, 16'h0}, 1'b1);
    chk("signSouth", 16'h1, {15'h0, gotData[13]});
    // Large field: readout held to the span of the corner
    sample <= 14'h1FFF;
    repeat (40) @(negedge clk);
    cmd('{CMD_READ, ADR_READOUT, 16'h0}, 1'b0);
    chk("readoutSpan", 16'h05E7, gotData);
    cmd('{CMD_WRITE, ADR_SENS, 16'h0800}, 1'b0);
    dac(16'h0000, 16'h0000, 16'h07FF, 16'h05E7);
    temperature <= 8'h90;
    repeat (4) @(negedge clk);
    chk("tempComp", 16'h05E9, {4'h0, dacCode});
    temperature <= 8'h80;
    cmd('{CMD_WRITE, ADR_MODE, 16'h0000}, 1'b0);
    repeat (4) @(negedge clk);
    cmd('{CMD_READ, ADR_READOUT, 16'h0}, 1'b0);
    chk("readout80Hz", 16'h0F7F, gotData);
    chk("dacSat", 16'h07FF, {4'h0, dacCode});
    cmd('{CMD_WRITE, ADR_MODE, 16'h0024}, 1'b0);
    cmd('{CMD_WRITE, ADR_SENS, 16'h0000}, 1'b0);
    dac(16'h07C0, 16'h0010, 16'h07FF, 16'h0010);
    $display("test span done");
    // host deselects through the output pin
    selectPin <= 1'b0;
    repeat (3) @(negedge clk);
    cmd('{CMD_WRITE, ADR_MODE, 16'h0000}, 1'b0);
    chk("unselReply", 16'h0, {15'h0, gotReply});
    selectPin <= 1'b1;
    repeat (3) @(negedge clk);
    cmd('{CMD_READ, ADR_MODE, 16'h0}, 1'b0);
    chk("modeKept", 16'h0024, gotData);
    cmd('{CMD_LOCK, ADR_LOCK, 16'h0001}, 1'b0);
    cmd('{CMD_READ, ADR_MODE, 16'h0}, 1'b0);
    chk("lockedRead", 16'h0, {15'h0, gotReply});
    cmd('{CMD_WRITE, ADR_QUIES, 16'h0100}, 1'b1);
    repeat (4) @(negedge clk);
    chk("lockedDac", 16'h0010, {4'h0, dacCode});
    $display("test lock done");
    results();
  end
endmodule
